/* File: pkg/dbs_pkg.sv */
package dbs_pkg;

   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int ADDR_W    = 21;            // Burst address bits per array
   localparam int WORD_W    = 18;            // One transfer on the data pins
   localparam int LANE_W    = 9;             // Bits per write lane
   localparam int LANES     = 2;             // Lanes per word
   localparam int BURST_W   = 2 * WORD_W;    // Two words committed together
   localparam int MASKS_W   = 2 * LANES;     // Lane masks for both words

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS     = 40;           // System clock period
   localparam int LOCK_US    = 20;           // Stable clock before lock
   localparam int STOP_NS    = 30;           // Least input clock stop for relock
   localparam int PLL_MIN_MHZ = 120;         // Lowest input rate the loop tracks
   localparam int LOCK_CYC_I = (LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int STOP_CYC_I = ((STOP_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                               (STOP_NS + CLK_NS - 1) / CLK_NS;
   localparam int K_HALF_MAX = 4;            // Longest sampled half period of k
   localparam logic [9:0] LOCK_CYC  = 10'(LOCK_CYC_I);
   localparam logic [3:0] STOP_LIM  = 4'(K_HALF_MAX + STOP_CYC_I);
   localparam logic [9:0] RECAL_CYC = 10'h3ff; // Last count of 1024

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [WORD_W-1:0] Q_RST   = 18'h00000;
   localparam logic [9:0]        CNT_RST = 10'h000;
   localparam logic [3:0]        STP_RST = 4'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic              k;
      logic              k_n;
      logic              c;
      logic              c_n;
      logic              pll_bypass_n;
      logic              read_port_sel_n;
      logic              write_port_sel_n;
      logic [LANES-1:0]  lane_write_mask_n;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] d;
   } dbs_pins_s;

   typedef enum logic [2:0] {
      RD_IDLE   = 3'b001,
      RD_SECOND = 3'b010,
      RD_TAIL   = 3'b100
   } dbs_rd_state_e;

endpackage : dbs_pkg

/* File: src/dbs_sram.sv */
`timescale 1ns/1ps
// Functional notes
// - One array, two-word burst from latched address
// - Read select at k rise latches address
// - PLL mode: word0 on c_n, word1 on c
// - Tristate after next output clock rise
// - Write select at k rise captures word0
// - Next k_n rise latches address, word1
// - Commit double-width burst after both words
// - Active-low lane masks gate each word
// - Deselected write port ignores its inputs
// - c and c_n high at start: single clock
// - Read and write ports run independently
// - Newest data returned, write data forwarded
// - Port selects sampled on k rise only
// - Deselect leaves other port, pending completes
// - Impedance recalibrated every 1024 cycles
// - Free-running echo strobes follow output clocks
// - PLL locks after 20 us stable clock
// - Stopped input clock resets the PLL
// - PLL tracks from 120 MHz upward
// - Bypass low: one-cycle read latency
// - Reset: ports deselected, outputs high impedance
module dbs_sram
   import dbs_pkg::*;
(
   // System
   input  wire logic              clock,
   input  wire logic              srst,
   // Input and output clock pins
   input  wire logic              k,
   input  wire logic              k_n,
   input  wire logic              c,
   input  wire logic              c_n,
   input  wire logic              pll_bypass_n,
   // Control and address pins
   input  wire logic              read_port_sel_n,
   input  wire logic              write_port_sel_n,
   input  wire logic [LANES-1:0]  lane_write_mask_n,
   input  wire logic [ADDR_W-1:0] addr,
   // Data pins
   input  wire logic [WORD_W-1:0] d,
   output logic      [WORD_W-1:0] q,
   output logic                   q_oe_n,
   // Echo strobes and housekeeping
   output logic                   echo_strobe,
   output logic                   echo_strobe_n,
   output logic                   pll_locked,
   output logic                   impedance_recal
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Keep the stored lane wherever its mask is high
   function automatic logic [BURST_W-1:0] lane_merge(input logic [BURST_W-1:0] old_v,
                                                     input logic [BURST_W-1:0] new_v,
                                                     input logic [MASKS_W-1:0] mask_n);
      logic [BURST_W-1:0] res;
      res = old_v;
      for (int i = 0; i < MASKS_W; i++) begin
         if (!mask_n[i]) begin
            res[i*LANE_W +: LANE_W] = new_v[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction : lane_merge
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   dbs_pins_s pins_s1_ff;
   dbs_pins_s pins_s2_ff;
   dbs_pins_s pins_s3_ff;
   dbs_pins_s pins_now;
   assign pins_now = '{k: k, k_n: k_n, c: c, c_n: c_n, pll_bypass_n: pll_bypass_n,
                       read_port_sel_n: read_port_sel_n,
                       write_port_sel_n: write_port_sel_n,
                       lane_write_mask_n: lane_write_mask_n, addr: addr, d: d};
   // All pins share one delay, so edges and data stay aligned
   always_ff @(posedge clock) begin
      pins_s1_ff <= pins_now;
      pins_s2_ff <= pins_s1_ff;
      pins_s3_ff <= pins_s2_ff;
   end

   // ------------------------------------------------------------
   // Clock strap and edge decode
   // ------------------------------------------------------------
   logic single_ff;
   logic strap_done_ff;
   // Caught once after release; the mode never changes later
   always_ff @(posedge clock) begin
      if (srst) begin
         single_ff     <= 1'b0;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         single_ff     <= pins_s2_ff.c & pins_s2_ff.c_n;
         strap_done_ff <= 1'b1;
      end
   end
   wire k_rise   = pins_s2_ff.k & ~pins_s3_ff.k;
   wire k_fall   = ~pins_s2_ff.k & pins_s3_ff.k;
   wire kn_rise  = pins_s2_ff.k_n & ~pins_s3_ff.k_n;
   wire pll_on   = pins_s2_ff.pll_bypass_n;
   wire oclk     = single_ff ? pins_s2_ff.k : pins_s2_ff.c;
   wire oclk_n   = single_ff ? pins_s2_ff.k_n : pins_s2_ff.c_n;
   wire oclk_d   = single_ff ? pins_s3_ff.k : pins_s3_ff.c;
   wire oclk_n_d = single_ff ? pins_s3_ff.k_n : pins_s3_ff.c_n;
   wire orise_p  = oclk & ~oclk_d;
   wire orise_n  = oclk_n & ~oclk_n_d;
   // Loop on: word0 on c_n rise; bypassed: word0 on c rise, word1 on c_n
   wire w0_edge  = pll_on ? orise_n : orise_p;
   wire w1_edge  = pll_on ? orise_p : orise_n;

   // ------------------------------------------------------------
   // Array and write port
   // ------------------------------------------------------------
   logic [BURST_W-1:0] mem_ff [2**ADDR_W];
   logic               wr_pend_ff;
   logic [WORD_W-1:0]  wr_word0_ff;
   logic [LANES-1:0]   wr_mask0_ff;
   // Selects only count on k rise; k_n rise only finishes a write
   wire wr_start  = k_rise & ~pins_s2_ff.write_port_sel_n;
   wire wr_commit = kn_rise & wr_pend_ff & ~srst;
   wire [BURST_W-1:0] wr_new = {pins_s2_ff.d, wr_word0_ff};
   wire [MASKS_W-1:0] wr_mask = {pins_s2_ff.lane_write_mask_n, wr_mask0_ff};
   wire [BURST_W-1:0] wr_merged = lane_merge(mem_ff[pins_s2_ff.addr], wr_new, wr_mask);
   // Word0 and its masks wait for the k_n rise that brings the address
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_pend_ff <= 1'b0;
      end else if (wr_start) begin
         wr_pend_ff <= 1'b1;
      end else if (wr_commit) begin
         wr_pend_ff <= 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (wr_start) begin
         wr_word0_ff <= pins_s2_ff.d;
         wr_mask0_ff <= pins_s2_ff.lane_write_mask_n;
      end
   end
   // Self-timed commit of both words in one step
   always_ff @(posedge clock) begin
      if (wr_commit) begin
         mem_ff[pins_s2_ff.addr] <= wr_merged;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   dbs_rd_state_e      rd_st_ff;
   dbs_rd_state_e      nxt_rd_st;
   logic               rd_pend_ff;
   logic [ADDR_W-1:0]  rd_addr_ff;
   logic [BURST_W-1:0] burst_ff;
   logic               burst_vld_ff;
   logic [WORD_W-1:0]  hold_ff;
   logic [WORD_W-1:0]  q_ff;
   logic               q_oe_n_ff;
   // Fetch one k rise after the start, after any commit of the prior write
   wire fetch_now = k_rise & rd_pend_ff;
   wire fwd_hit   = wr_commit & (pins_s2_ff.addr == rd_addr_ff);
   wire [BURST_W-1:0] fetched = fwd_hit ? wr_merged : mem_ff[rd_addr_ff];
   wire w0_avail  = fetch_now | burst_vld_ff;
   wire [BURST_W-1:0] w0_src = fetch_now ? fetched : burst_ff;
   wire w0_fire   = w0_edge & w0_avail & (rd_st_ff != RD_SECOND);
   wire w1_fire   = w1_edge & (rd_st_ff == RD_SECOND);
   wire tail_off  = (rd_st_ff == RD_TAIL) & (orise_p | orise_n) & ~w0_fire;
   // Address latch is independent of the write port
   always_ff @(posedge clock) begin
      if (srst) begin
         rd_pend_ff <= 1'b0;
      end else if (k_rise) begin
         rd_pend_ff <= ~pins_s2_ff.read_port_sel_n;
      end
   end
   always_ff @(posedge clock) begin
      if (k_rise && !pins_s2_ff.read_port_sel_n) begin
         rd_addr_ff <= pins_s2_ff.addr;
      end
   end
   // Fetched burst waits for its first output edge
   always_ff @(posedge clock) begin
      if (srst) begin
         burst_vld_ff <= 1'b0;
      end else if (fetch_now && !w0_fire) begin
         burst_vld_ff <= 1'b1;
      end else if (w0_fire) begin
         burst_vld_ff <= 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (fetch_now) begin
         burst_ff <= fetched;
      end
   end
   // Sequencer for the two output words and the release
   always_comb begin
      nxt_rd_st = rd_st_ff;
      case (rd_st_ff)
         RD_IDLE:   if (w0_fire) nxt_rd_st = RD_SECOND;
         RD_SECOND: if (w1_fire) nxt_rd_st = RD_TAIL;
         RD_TAIL: begin
            if (w0_fire) begin
               nxt_rd_st = RD_SECOND;
            end else if (tail_off) begin
               nxt_rd_st = RD_IDLE;
            end
         end
         default:   nxt_rd_st = RD_IDLE;
      endcase
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         rd_st_ff <= RD_IDLE;
      end else begin
         rd_st_ff <= nxt_rd_st;
      end
   end
   // Word1 is parked so a new fetch cannot overwrite it
   always_ff @(posedge clock) begin
      if (w0_fire) begin
         hold_ff <= w0_src[BURST_W-1:WORD_W];
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         q_ff      <= Q_RST;
         q_oe_n_ff <= 1'b1;
      end else if (w0_fire) begin
         q_ff      <= w0_src[WORD_W-1:0];
         q_oe_n_ff <= 1'b0;
      end else if (w1_fire) begin
         q_ff      <= hold_ff;
      end else if (tail_off) begin
         q_oe_n_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Echo strobes, loop lock and impedance timer
   // ------------------------------------------------------------
   logic       echo_ff;
   logic       echo_n_ff;
   logic [3:0] stop_cnt_ff;
   logic [9:0] lock_cnt_ff;
   logic       locked_ff;
   logic [9:0] recal_cnt_ff;
   logic       recal_ff;
   // A k idling past the stop limit counts as slowed below PLL_MIN_MHZ
   wire k_stopped = (stop_cnt_ff >= STOP_LIM);
   always_ff @(posedge clock) begin
      if (srst) begin
         echo_ff   <= 1'b0;
         echo_n_ff <= 1'b0;
      end else begin
         echo_ff   <= oclk;
         echo_n_ff <= oclk_n;
      end
   end
   // Stop detector; with no edges the lock logic clears, the recal timer keeps counting
   always_ff @(posedge clock) begin
      if (srst || k_rise || k_fall) begin
         stop_cnt_ff <= STP_RST;
      end else if (!k_stopped) begin
         stop_cnt_ff <= stop_cnt_ff + 4'h1;
      end
   end
   always_ff @(posedge clock) begin
      if (srst || k_stopped || !pll_on) begin
         lock_cnt_ff <= CNT_RST;
         locked_ff   <= 1'b0;
      end else if (lock_cnt_ff == LOCK_CYC - 10'h001) begin
         locked_ff   <= 1'b1;
      end else begin
         lock_cnt_ff <= lock_cnt_ff + 10'h001;
      end
   end
   // Free-running recalibration strobe, one cycle wide
   always_ff @(posedge clock) begin
      if (srst) begin
         recal_cnt_ff <= CNT_RST;
         recal_ff     <= 1'b0;
      end else begin
         recal_cnt_ff <= recal_cnt_ff + 10'h001;
         recal_ff     <= (recal_cnt_ff == RECAL_CYC);
      end
   end
   assign q               = q_ff;
   assign q_oe_n          = q_oe_n_ff;
   assign echo_strobe     = echo_ff;
   assign echo_strobe_n   = echo_n_ff;
   assign pll_locked      = locked_ff;
   assign impedance_recal = recal_ff;
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_reset_release: assert property (@(posedge clock)
      srst |=> q_oe_n_ff && !wr_pend_ff && !rd_pend_ff)
      else $error("outputs not released by reset");
   a_first_word: assert property (@(posedge clock) disable iff (srst)
      w0_fire |=> !q_oe_n_ff && q_ff == $past(w0_src[WORD_W-1:0]))
      else $error("first word not driven");
   a_second_word: assert property (@(posedge clock) disable iff (srst)
      w1_fire |=> q_ff == $past(hold_ff) && !q_oe_n_ff)
      else $error("second word wrong");
   a_tail_release: assert property (@(posedge clock) disable iff (srst)
      tail_off |=> q_oe_n_ff && rd_st_ff == RD_IDLE)
      else $error("outputs not released after burst");
   a_read_start: assert property (@(posedge clock) disable iff (srst)
      (k_rise && !pins_s2_ff.read_port_sel_n) |=> rd_pend_ff &&
      rd_addr_ff == $past(pins_s2_ff.addr)) else $error("read start not latched");
   a_sel_k_only: assert property (@(posedge clock) disable iff (srst)
      (!k_rise && !wr_commit) |=> $stable(rd_pend_ff) && $stable(wr_pend_ff))
      else $error("select sampled off k rise");
   a_write_commit: assert property (@(posedge clock) disable iff (srst)
      wr_commit |=> !wr_pend_ff && mem_ff[$past(pins_s2_ff.addr)] == $past(wr_merged))
      else $error("burst not committed");
   a_forward_new: assert property (@(posedge clock) disable iff (srst)
      (fetch_now && fwd_hit) |=> burst_ff == $past(wr_merged) ||
      q_ff == $past(wr_merged[WORD_W-1:0])) else $error("write data not forwarded");
   a_strap_fixed: assert property (@(posedge clock) disable iff (srst)
      strap_done_ff |=> $stable(single_ff))
      else $error("clock mode changed in operation");
   a_echo_follow: assert property (@(posedge clock) disable iff (srst)
      single_ff ##1 single_ff |-> echo_ff == $past(pins_s2_ff.k) &&
      echo_n_ff == $past(pins_s2_ff.k_n)) else $error("echo strobe not following k");
   a_lock_time: assert property (@(posedge clock) disable iff (srst)
      $rose(locked_ff) |-> $past(lock_cnt_ff) == LOCK_CYC - 10'h001)
      else $error("lock at wrong count");
   a_recal_period: assert property (@(posedge clock) disable iff (srst)
      recal_ff |=> !recal_ff [*8])
      else $error("recalibration strobe too frequent");
endmodule : dbs_sram

/* File: sim/dbs_ctrl_model.sv */
`timescale 1ns/1ps
module dbs_ctrl_model
   import dbs_pkg::*;
(
   // Clock source and strap
   input  wire logic               clock,
   input  wire logic               run,
   input  wire logic               single,
   input  wire logic               bypass_n,
   // Command for the next k cycle
   input  wire logic               rd_go,
   input  wire logic               wr_go,
   input  wire logic [ADDR_W-1:0]  rd_addr,
   input  wire logic [ADDR_W-1:0]  wr_addr,
   input  wire logic [BURST_W-1:0] wr_data,
   input  wire logic [MASKS_W-1:0] wr_mask_n,
   // Pins toward the memory
   output dbs_pins_s               pins,
   output logic [2:0]              ph_ff
);
   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   logic              k_lvl;
   logic              rs_ff = 1'b1;
   logic              ws_ff = 1'b1;
   logic [LANES-1:0]  m_ff  = 2'h3;
   logic [ADDR_W-1:0] a_ff  = 21'h0;
   logic [WORD_W-1:0] d_ff  = 18'h0;

   initial ph_ff = 3'd0;

   // Six system clocks per k cycle; a stop freezes both pairs in place
   assign k_lvl = (ph_ff < 3'd3);
   // Parking the c pair high straps the memory into single clock mode
   assign pins = '{k: k_lvl, k_n: !k_lvl, c: single | k_lvl, c_n: single | !k_lvl,
                   pll_bypass_n: bypass_n, read_port_sel_n: rs_ff, write_port_sel_n: ws_ff,
                   lane_write_mask_n: m_ff, addr: a_ff, d: d_ff};

   // Pins move on the same system clock as each k or k_n rise
   always @(posedge clock) begin
      if (run) begin
         ph_ff <= (ph_ff == 3'd5) ? 3'd0 : ph_ff + 3'd1;
      end
      if (run && ph_ff == 3'd5) begin
         rs_ff <= !rd_go;
         ws_ff <= !wr_go;
         a_ff  <= rd_addr;
         d_ff  <= wr_go ? wr_data[WORD_W-1:0] : ~d_ff;
         m_ff  <= wr_mask_n[LANES-1:0];
      end
      if (run && ph_ff == 3'd2) begin
         // Selects low in the k_n half are a trap: they must not start anything
         rs_ff <= 1'b0;
         ws_ff <= 1'b0;
         a_ff  <= wr_go ? wr_addr : ~a_ff;
         d_ff  <= wr_go ? wr_data[BURST_W-1:WORD_W] : ~d_ff;
         m_ff  <= wr_mask_n[MASKS_W-1:LANES];
      end
   end
endmodule : dbs_ctrl_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench
   import dbs_pkg::*;
;
   // ------------------------------------------------------------
   // Signals and reference state
   // ------------------------------------------------------------
   logic               clock;
   logic               srst;
   logic               run;
   logic               single;
   logic               bypass_n;
   logic               rd_go;
   logic               wr_go;
   logic [ADDR_W-1:0]  rd_addr;
   logic [ADDR_W-1:0]  wr_addr;
   logic [BURST_W-1:0] wr_data;
   logic [MASKS_W-1:0] wr_mask_n;
   dbs_pins_s          pins;
   logic [2:0]         ph_ff;
   logic [2:0]         last_ph;
   logic [WORD_W-1:0]  q;
   logic               q_oe_n;
   logic               echo_strobe;
   logic               echo_strobe_n;
   logic               pll_locked;
   logic               impedance_recal;
   logic               seen_p;
   logic [BURST_W-1:0] mem [int];
   logic [ADDR_W-1:0]  tbl [8];
   int                 due_q [$];
   logic [WORD_W-1:0]  word_q [$];
   int                 n_mismatch;
   int                 check_count;
   int                 hc;
   int                 cyc;
   int                 gap;
   int                 seed;

   dbs_ctrl_model ctrl (.clock(clock), .run(run), .single(single), .bypass_n(bypass_n),
      .rd_go(rd_go), .wr_go(wr_go), .rd_addr(rd_addr), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_mask_n(wr_mask_n), .pins(pins), .ph_ff(ph_ff));

   dbs_sram DUT (.clock(clock), .srst(srst), .k(pins.k), .k_n(pins.k_n), .c(pins.c),
      .c_n(pins.c_n), .pll_bypass_n(pins.pll_bypass_n),
      .read_port_sel_n(pins.read_port_sel_n), .write_port_sel_n(pins.write_port_sel_n),
      .lane_write_mask_n(pins.lane_write_mask_n), .addr(pins.addr), .d(pins.d), .q(q),
      .q_oe_n(q_oe_n), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n),
      .pll_locked(pll_locked), .impedance_recal(impedance_recal));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task end_of_test;
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // One k cycle of commands; the model books results by sample index
   task slot(input logic rd, input logic wr, input logic [ADDR_W-1:0] ra,
             input logic [ADDR_W-1:0] wa, input logic [BURST_W-1:0] wd,
             input logic [MASKS_W-1:0] wm);
      @(negedge clock iff (ph_ff == 3'd4));
      @(posedge clock);
      rd_go     <= rd;
      wr_go     <= wr;
      rd_addr   <= ra;
      wr_addr   <= wa;
      wr_data   <= wd;
      wr_mask_n <= wm;
      for (int b = 0; b < MASKS_W; b++) begin
         if (wr && !wm[b]) mem[wa][b*LANE_W +: LANE_W] = wd[b*LANE_W +: LANE_W];
      end
      if (rd) begin
         due_q.push_back(hc + (bypass_n ? 5 : 4));
         word_q.push_back(mem[ra][WORD_W-1:0]);
         due_q.push_back(hc + (bypass_n ? 6 : 5));
         word_q.push_back(mem[ra][BURST_W-1:WORD_W]);
      end
   endtask : slot

   // Reset into one clocking mode, then traffic with a clock stop midway
   task mode(input logic sgl, input logic byp, input logic lck);
      logic [WORD_W-1:0] qs;
      @(posedge clock);
      srst     <= 1'b1;
      single   <= sgl;
      bypass_n <= byp;
      repeat (20) @(posedge clock);
      @(negedge clock);
      check(WORD_W'(q_oe_n), 18'h1);
      @(posedge clock);
      srst <= 1'b0;
      due_q.delete();
      word_q.delete();
      if (lck) begin
         repeat (LOCK_CYC_I - 20) @(posedge clock);
         @(negedge clock);
         check(WORD_W'(pll_locked), 18'h0);
         repeat (40) @(posedge clock);
         @(negedge clock);
         check(WORD_W'(pll_locked), 18'h1);
      end
      for (int i = 0; i < 8; i++) slot(1'b0, 1'b1, tbl[0], tbl[i],
         BURST_W'({$random(seed), $random(seed)}), 4'h0);
      for (int i = 0; i < 200; i++) begin
         slot(1'($random(seed)), 1'($random(seed)), tbl[(i + 7) % 8], tbl[i % 8],
              BURST_W'({$random(seed), $random(seed)}), 4'($random(seed)));
         if (i == 100) begin
            // Parked with k low so the echo phase is sane on restart
            run <= 1'b0;
            repeat (4) @(posedge clock);
            @(negedge clock);
            qs = q;
            repeat (10) @(posedge clock);
            @(negedge clock);
            check(q, qs);
            check(WORD_W'(pll_locked), 18'h0);
            @(posedge clock);
            run <= 1'b1;
         end
      end
      for (int i = 0; i < 4; i++) slot(1'b0, 1'b0, tbl[0], tbl[0],
         BURST_W'({$random(seed), $random(seed)}), 4'h0);
      @(negedge clock);
      check(WORD_W'(due_q.size()), 18'h0);
      if (!byp) check(WORD_W'(pll_locked), 18'h0);
   endtask : mode

   // ------------------------------------------------------------
   // Monitors
   // ------------------------------------------------------------
   // Samples q two clocks and the echo strobes one clock after each expected change, so sync jitter is absorbed
   always @(negedge clock) begin
      if (ph_ff != last_ph && cyc > 8) begin
         if (ph_ff == 3'd2 || ph_ff == 3'd5) begin
            if (due_q.size() > 0 && due_q[0] == hc) begin
               check(WORD_W'(q_oe_n), 18'h0);
               check(q, word_q[0]);
               void'(due_q.pop_front());
               void'(word_q.pop_front());
            end else begin
               check(WORD_W'(q_oe_n), 18'h1);
            end
         end
         if (ph_ff == 3'd1 || ph_ff == 3'd4) begin
            check(WORD_W'(echo_strobe), WORD_W'(ph_ff == 3'd4));
            check(WORD_W'(echo_strobe_n), WORD_W'(ph_ff == 3'd1));
         end
      end
      if (ph_ff != last_ph && (ph_ff == 3'd2 || ph_ff == 3'd5)) hc++;
      last_ph = ph_ff;
   end

   // Recalibration spacing; a clock stop re-arms the measurement
   always @(posedge clock) begin
      cyc <= srst ? 0 : cyc + 1;
      gap <= impedance_recal ? 1 : gap + 1;
      if (srst || !run) seen_p <= 1'b0;
      else if (impedance_recal) begin
         if (seen_p) check(WORD_W'(gap), 18'h00400);
         seen_p <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Clock, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #(CLK_NS / 2) clock = ~clock;
   end

   initial begin
      srst = 1'b1;
      run = 1'b1;
      single = 1'b0;
      bypass_n = 1'b1;
      rd_go = 1'b0;
      wr_go = 1'b0;
      rd_addr = 21'h0;
      wr_addr = 21'h0;
      wr_data = 36'h0;
      wr_mask_n = 4'hf;
      last_ph = 3'd0;
      seen_p = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      hc = 0;
      cyc = 0;
      gap = 0;
      seed = 32'heb8bbe1f;
      for (int i = 0; i < 8; i++) tbl[i] = ADDR_W'($random(seed));
      mode(1'b0, 1'b1, 1'b1);
      mode(1'b1, 1'b1, 1'b0);
      mode(1'b0, 1'b0, 1'b0);
      end_of_test();
   end

   // Whole run is near 4500 clocks; this limit leaves a wide margin
   initial begin
      #(CLK_NS * 20000);
      n_mismatch++;
      $display("BAD t=%0t watchdog expired", $time);
      end_of_test();
   end
endmodule : testbench
